/* verilog/cke_power_save_pkg.sv */
// Constants shared by the clock-enable power-save sequencer and its counters.
package cke_power_save_pkg;

	// ********************************************************************
	// Clock and time base
	// ********************************************************************
	localparam int REF_CLK_PERIOD_PS = 8000;
	// The sequencer is clocked by the registered input clock, so one tCK is one ref_clk period.
	localparam int TCK_PS = REF_CLK_PERIOD_PS;

	// ********************************************************************
	// Times in input clock cycles (tCK)
	// ********************************************************************
	localparam int ACTIVE_TIME_TCK = 8;
	localparam int PROGRAMMING_SPACING_TCK = 8;
	localparam int INDIS_MIN_TCK = 1;
	localparam int INDIS_MAX_TCK = 4;
	localparam int INDIS_CHOSEN_TCK = 2;
	localparam int CKOFF_TCK = 5;
	localparam int CKEV_TCK = 2;
	localparam int FIXED_OUT_MIN_TCK = 1;
	localparam int FIXED_OUT_MAX_TCK = 3;

	// ********************************************************************
	// Cycle counts (least times round up)
	// ********************************************************************
	localparam int ACTIVE_CYCLES = (ACTIVE_TIME_TCK * TCK_PS + REF_CLK_PERIOD_PS - 1) / REF_CLK_PERIOD_PS;
	localparam int SPACING_CYCLES = (PROGRAMMING_SPACING_TCK * TCK_PS + REF_CLK_PERIOD_PS - 1) / REF_CLK_PERIOD_PS;
	localparam int INDIS_CYCLES = (INDIS_CHOSEN_TCK * TCK_PS + REF_CLK_PERIOD_PS - 1) / REF_CLK_PERIOD_PS;
	localparam int CKOFF_CYCLES = (CKOFF_TCK * TCK_PS + REF_CLK_PERIOD_PS - 1) / REF_CLK_PERIOD_PS;
	localparam int CKEV_CYCLES = (CKEV_TCK * TCK_PS + REF_CLK_PERIOD_PS - 1) / REF_CLK_PERIOD_PS;

	// ********************************************************************
	// Power-save control word layout and reset value
	// ********************************************************************
	localparam int PS_STYLE_POS = 0;
	localparam int PS_ENABLE_POS = 1;
	localparam logic [1:0] CTRL_WORD_RESET = 2'h0;

	// ********************************************************************
	// Widths
	// ********************************************************************
	localparam int RUN_COUNT_W = 4;
	localparam int CHIP_SELECT_W = 4;

endpackage

/* verilog/run_length_counter.sv */
// Saturating counter of consecutive cycles during which a condition holds.
`timescale 1ns/1ps
module run_length_counter #(
	parameter int WIDTH = 4
) (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic run,
	output logic [WIDTH-1:0] count
);

	typedef struct packed {
		logic [WIDTH-1:0] count;
	} run_state_type;

	run_state_type s_q;
	run_state_type s_d;

	if (WIDTH < 2) begin : g_width_check
		$error("run_length_counter needs at least two bits");
	end

	// Saturation keeps a long idle period from wrapping back to a short count.
	always_comb begin
		s_d = s_q;
		if (!run) begin
			s_d.count = '0;
		end else if (s_q.count != {WIDTH{1'b1}}) begin
			s_d.count = s_q.count + WIDTH'(1);
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign count = s_q.count;

endmodule

/* verilog/cke_power_save_sequencer.sv */
// Clock-enable driven power-save sequencer of a registering clock driver.
// Operation
// R1: Controller holds clock enables low, chip selects high 8 cycles before reset release.
// R2: Controller spaces control-word programming accesses at least 8 cycles apart.
// R3: With power save enabled, disable input buffers 1 to 4 cycles after enables low.
// R4: Float output buffers 1.5 cycles after registered clock enables go low.
// R5: Controller holds enables low 5 toggling cycles before stopping the clock.
// R6: Disable clock-enable input buffers 2 or more cycles after clock held low.
// R7: On exit, drive static outputs again within 1 to 3 cycles.
// R8: All intervals save R1 are reset counters on the input clock, idle during reset; the 1.5-cycle float delay is a posedge and a negedge flop instead.
`timescale 1ns/1ps
module cke_power_save_sequencer #(
	parameter int CS_W = cke_power_save_pkg::CHIP_SELECT_W,
	parameter int CNT_W = cke_power_save_pkg::RUN_COUNT_W
) (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic clock_enable_in_zero,
	input wire logic clock_enable_in_one,
	input wire logic [CS_W-1:0] chip_select_inputs,
	input wire logic clock_held_low,
	input wire logic program_strobe,
	input wire logic power_save_enable_bit,
	input wire logic power_save_style_bit,
	output logic [1:0] registered_clock_enable_outputs,
	output logic [1:0] power_save_control_word,
	output logic input_buffers_enable,
	output logic cke_input_buffers_enable,
	output logic output_float,
	output logic static_outputs_driven,
	output logic programming_accepted,
	output logic programming_refused,
	output logic clock_stop_early,
	output logic reset_entry_idle
);
	import cke_power_save_pkg::*;

	// ********************************************************************
	// State
	// ********************************************************************
	typedef struct packed {
		logic [1:0] cke_out;
		logic [1:0] ctrl_word;
		logic prog_seen;
		logic prog_accept;
		logic prog_refuse;
		logic in_buf_en;
		logic cke_buf_en;
		logic float_pre;
		logic clk_low_seen;
		logic clk_stop_early;
		logic idle;
	} seq_state_type;

	seq_state_type s_q;
	seq_state_type s_d;
	logic float_half_q;
	logic [1:0] cke_seen;
	logic both_low;
	logic ps_on;
	logic accept;
	logic [CNT_W-1:0] low_cnt;
	logic [CNT_W-1:0] clk_low_cnt;
	logic [CNT_W-1:0] spacing_cnt;

	if (CNT_W < 4 || (1 << CNT_W) <= SPACING_CYCLES || (1 << CNT_W) <= CKOFF_CYCLES) begin : g_cnt_check
		$error("counter width too small for the documented intervals");
	end
	if (CS_W != 2 && CS_W != 4) begin : g_cs_check
		$error("chip select width must be 2 or 4");
	end

	// ********************************************************************
	// Interval counters
	// ********************************************************************
	// Once the clock-enable buffers are off the enables read as low, so the run continues until wake-up.
	assign cke_seen = s_q.cke_buf_en ? {clock_enable_in_one, clock_enable_in_zero} : 2'h0;
	assign both_low = (cke_seen == 2'h0);
	assign ps_on = s_q.ctrl_word[PS_ENABLE_POS];

	run_length_counter #(.WIDTH(CNT_W)) u_low_run ( // [R8]
		.ref_clk(ref_clk),
		.rstn(rstn),
		.run(both_low),
		.count(low_cnt)
	);

	run_length_counter #(.WIDTH(CNT_W)) u_clk_low_run ( // [R8]
		.ref_clk(ref_clk),
		.rstn(rstn),
		.run(both_low && clock_held_low),
		.count(clk_low_cnt)
	);

	run_length_counter #(.WIDTH(CNT_W)) u_spacing_run ( // [R8]
		.ref_clk(ref_clk),
		.rstn(rstn),
		.run(!program_strobe),
		.count(spacing_cnt)
	);

	// ********************************************************************
	// Next state
	// ********************************************************************
	// The first access after reset has no predecessor, so it is never refused.
	assign accept = program_strobe && (!s_q.prog_seen || spacing_cnt >= CNT_W'(SPACING_CYCLES - 1)); // [R2]

	always_comb begin
		s_d = s_q;
		s_d.cke_out = cke_seen;
		s_d.prog_accept = accept;
		s_d.prog_refuse = program_strobe && !accept; // [R2]
		if (accept) begin
			s_d.prog_seen = 1'b1;
			s_d.ctrl_word[PS_ENABLE_POS] = power_save_enable_bit;
			s_d.ctrl_word[PS_STYLE_POS] = power_save_style_bit;
		end
		s_d.in_buf_en = !(ps_on && both_low && low_cnt >= CNT_W'(INDIS_CYCLES - 1)); // [R3]
		s_d.cke_buf_en = !(both_low && clock_held_low && clk_low_cnt >= CNT_W'(CKEV_CYCLES - 1)); // [R6]
		// Floating follows the registered enables, so wake-up also takes the same 1.5 cycles.
		s_d.float_pre = ps_on && (s_q.cke_out == 2'h0); // [R4] [R7]
		s_d.clk_low_seen = clock_held_low;
		s_d.clk_stop_early = clock_held_low && !s_q.clk_low_seen && low_cnt < CNT_W'(CKOFF_CYCLES); // [R5]
		s_d.idle = ({clock_enable_in_one, clock_enable_in_zero} == 2'h0) && (&chip_select_inputs); // [R1]
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			s_q <= '{cke_out: 2'h0, ctrl_word: CTRL_WORD_RESET, prog_seen: 1'b0, prog_accept: 1'b0,
				prog_refuse: 1'b0, in_buf_en: 1'b1, cke_buf_en: 1'b1, float_pre: 1'b0,
				clk_low_seen: 1'b0, clk_stop_early: 1'b0, idle: 1'b0}; // [R8]
		end else begin
			s_q <= s_d;
		end
	end

	// The half-cycle step needs the falling edge; it is the only state kept outside the struct.
	always_ff @(negedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			float_half_q <= 1'b0;
		end else begin
			float_half_q <= s_q.float_pre; // [R4]
		end
	end

	// ********************************************************************
	// Outputs
	// ********************************************************************
	assign registered_clock_enable_outputs = s_q.cke_out;
	assign power_save_control_word = s_q.ctrl_word;
	assign input_buffers_enable = s_q.in_buf_en;
	assign cke_input_buffers_enable = s_q.cke_buf_en;
	assign output_float = float_half_q;
	assign static_outputs_driven = !float_half_q;
	assign programming_accepted = s_q.prog_accept;
	assign programming_refused = s_q.prog_refuse;
	assign clock_stop_early = s_q.clk_stop_early;
	assign reset_entry_idle = s_q.idle;

	// ********************************************************************
	// Assertions
	// ********************************************************************
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rstn);

	AST_INDIS_LATE: assert property ((ps_on && both_low)[*2] |=> !input_buffers_enable) // [R3]
		else $error("input buffers not disabled two cycles after enables went low");

	AST_INDIS_EARLY: assert property ($rose(both_low) |-> input_buffers_enable) // [R3]
		else $error("input buffers disabled before one cycle had passed");

	AST_QDIS: assert property (ps_on && $fell(|registered_clock_enable_outputs) |-> !output_float ##1 output_float) // [R4]
		else $error("outputs did not float 1.5 cycles after registered enables fell");

	AST_QDIS_HALF: assert property (output_float == s_q.float_pre) // [R4]
		else $error("float output is not the half-cycle copy of its posedge stage");

	AST_CKEV_MIN: assert property ($rose(clock_held_low) |-> cke_input_buffers_enable[*2]) // [R6]
		else $error("clock-enable buffers disabled within two cycles of clock stop");

	AST_CKEV_OFF: assert property ((both_low && clock_held_low)[*2] |=> !cke_input_buffers_enable) // [R6]
		else $error("clock-enable buffers still on after clock held low two cycles");

	AST_WAKE: assert property (output_float && ps_on && !both_low |-> ##[1:3] !output_float) // [R7]
		else $error("static outputs not driven within three cycles of wake-up");

	AST_RESET_EXIT: assert property ($rose(rstn) |-> input_buffers_enable && cke_input_buffers_enable
		&& !output_float && power_save_control_word == CTRL_WORD_RESET) // [R8]
		else $error("sequencer not idle at reset release");

	AST_SPACING: assert property (programming_accepted |=> !programming_accepted[*7]) // [R2]
		else $error("two programming accesses accepted closer than eight cycles");

	COV_ENTER: cover property (ps_on && $rose(output_float));
	COV_WAKE: cover property ($fell(output_float));
	COV_CLOCK_STOP: cover property ($fell(cke_input_buffers_enable));
	COV_REFUSE: cover property (programming_refused);

endmodule

/* dv/dram_ctrl_model.sv */
// Behavioural memory controller that drives the command side of the sequencer.
`timescale 1ns/1ps
module dram_ctrl_model (
	input wire logic ref_clk,
	output logic rstn,
	output logic clock_enable_in_zero,
	output logic clock_enable_in_one,
	output logic [3:0] chip_select_inputs,
	output logic clock_held_low,
	output logic program_strobe,
	output logic power_save_enable_bit,
	output logic power_save_style_bit
);
	int gap_q = 8;
	int low_q = 0;

	initial begin
		rstn = 1'b0;
		clock_enable_in_zero = 1'b0;
		clock_enable_in_one = 1'b0;
		chip_select_inputs = 4'hF;
		clock_held_low = 1'b0;
		program_strobe = 1'b0;
		power_save_enable_bit = 1'b0;
		power_save_style_bit = 1'b0;
	end

	always @(posedge ref_clk) begin
		gap_q <= program_strobe ? 0 : gap_q + 1;
		low_q <= (clock_enable_in_zero | clock_enable_in_one) ? 0 : low_q + 1;
	end

	task automatic do_reset();
		@(negedge ref_clk);
		rstn = 1'b0;
		clock_enable_in_zero = 1'b0;
		clock_enable_in_one = 1'b0;
		chip_select_inputs = 4'hF;
		clock_held_low = 1'b0;
		repeat (8) @(negedge ref_clk);
		rstn = 1'b1;
	endtask

	// Data lines are inverted once the strobe drops, so a stale value is never read as valid.
	task automatic prog(input logic en, input logic style, input bit obey);
		while (obey && gap_q < 7) @(negedge ref_clk);
		program_strobe = 1'b1;
		power_save_enable_bit = en;
		power_save_style_bit = style;
		@(negedge ref_clk);
		program_strobe = 1'b0;
		power_save_enable_bit = ~en;
		power_save_style_bit = ~style;
	endtask

	// Back-to-back accesses: the strobe stands over two edges, and the second access carries the other data.
	task automatic prog_pair(input logic en, input logic style);
		program_strobe = 1'b1;
		power_save_enable_bit = en;
		power_save_style_bit = style;
		@(negedge ref_clk);
		power_save_enable_bit = ~en;
		power_save_style_bit = ~style;
		@(negedge ref_clk);
		program_strobe = 1'b0;
		power_save_enable_bit = en;
		power_save_style_bit = style;
	endtask

	task automatic set_cs(input logic [3:0] v);
		chip_select_inputs = v;
	endtask

	task automatic set_cke(input logic [1:0] v);
		clock_enable_in_one = v[1];
		clock_enable_in_zero = v[0];
	endtask

	task automatic stop_clock(input bit obey);
		while (obey && low_q < 5) @(negedge ref_clk);
		clock_held_low = 1'b1;
	endtask

	task automatic start_clock();
		clock_held_low = 1'b0;
	endtask
endmodule

/* dv/tb_cke_power_save_sequencer.sv */
// Self-checking testbench of the clock-enable power-save sequencer.
`timescale 1ns/1ps
module tb_cke_power_save_sequencer;
	logic ref_clk, rstn, ck0, ck1, held, strobe, en_b, st_b;
	logic [3:0] cs_n, cs_v;
	logic [1:0] cke_q, word, w;
	logic ib, ckib, flt, drv, acc, refd, early, idle, e;
	int err_total = 0;
	int total_checks = 0;
	int d, g;

	dram_ctrl_model m_u (.ref_clk(ref_clk), .rstn(rstn), .clock_enable_in_zero(ck0), .clock_enable_in_one(ck1),
		.chip_select_inputs(cs_n), .clock_held_low(held), .program_strobe(strobe),
		.power_save_enable_bit(en_b), .power_save_style_bit(st_b));

	cke_power_save_sequencer #(.CS_W(4)) dut_u (.ref_clk(ref_clk), .rstn(rstn), .clock_enable_in_zero(ck0),
		.clock_enable_in_one(ck1), .chip_select_inputs(cs_n), .clock_held_low(held), .program_strobe(strobe),
		.power_save_enable_bit(en_b), .power_save_style_bit(st_b), .registered_clock_enable_outputs(cke_q),
		.power_save_control_word(word), .input_buffers_enable(ib), .cke_input_buffers_enable(ckib),
		.output_float(flt), .static_outputs_driven(drv), .programming_accepted(acc),
		.programming_refused(refd), .clock_stop_early(early), .reset_entry_idle(idle));

	task automatic check(input logic [3:0] seen, input logic [3:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic tally_and_finish();
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end

	// The run needs well under two hundred cycles; the 5000-cycle limit leaves a wide margin.
	initial begin
		#40000;
		err_total++;
		tally_and_finish();
	end

	// ********************************************************************
	// Main sequence
	// ********************************************************************
	initial begin
		void'($urandom(26089));
		m_u.do_reset();
		@(negedge ref_clk);
		check({ib, ckib, flt, idle}, 4'hD);
		m_u.prog(1'b0, 1'b1, 1'b1);
		w = 2'h1;
		check({acc, refd, word}, {2'h2, w});
		for (int i = 0; i < 8; i++) begin
			// A one-cycle gap would need the strobe to stay high, so that case is left to the pair below.
			g = (i == 0) ? 2 : (i == 1) ? 8 : $urandom_range(12, 2);
			e = 1'($urandom_range(1, 0));
			repeat (g - 1) @(negedge ref_clk);
			m_u.prog(e, ~e, 1'b0);
			if (g >= 8) w = {e, ~e};
			check({acc, refd, word}, {g >= 8, g < 8, w});
		end
		// The first strobe of the pair keeps its distance, and the second follows on the very next edge.
		repeat (7) @(negedge ref_clk);
		e = 1'($urandom_range(1, 0));
		fork
			m_u.prog_pair(e, ~e);
			begin
				@(negedge ref_clk);
				check({acc, refd, word}, {2'h2, e, ~e});
			end
		join
		check({acc, refd, word}, {2'h1, e, ~e});
		for (int en = 0; en < 2; en++) begin
			m_u.set_cke(2'h3);
			m_u.prog(1'(en), 1'($urandom_range(1, 0)), 1'b1);
			m_u.set_cke(2'h0);
			@(negedge ref_clk) #1;
			d = (ib === 1'b0) ? 1 : 2;
			check({cke_q, flt}, 4'h0);
			@(posedge ref_clk) #1;
			check(4'(flt), 4'h0);
			@(negedge ref_clk) #1;
			check(4'(flt), 4'(en));
			while (ib !== 1'b0 && d < 6) begin
				@(negedge ref_clk);
				d++;
			end
			check(4'(d >= 1 && d <= 4), 4'(en));
		end
		m_u.stop_clock(1'b1);
		d = 0;
		do begin
			@(negedge ref_clk);
			d++;
		end while (ckib !== 1'b0 && d < 8);
		check({4'(d >= 2 && d < 8)}, 4'h1);
		m_u.start_clock();
		repeat (2) @(negedge ref_clk);
		m_u.set_cke(2'h1);
		d = 0;
		do begin
			@(negedge ref_clk) #1;
			d++;
		end while (flt !== 1'b0 && d < 6);
		check(4'(d >= 1 && d <= 3), 4'h1);
		check({cke_q, ib, drv}, 4'h7);
		m_u.set_cke(2'h0);
		repeat (2) @(negedge ref_clk);
		m_u.stop_clock(1'b0);
		e = 1'b0;
		repeat (3) begin
			@(negedge ref_clk);
			e = e | early;
		end
		check(4'(e), 4'h1);
		m_u.start_clock();
		repeat (6) @(negedge ref_clk);
		check(4'(ib), 4'h0);
		fork
			m_u.do_reset();
			begin
				@(negedge ref_clk) #1;
				check({ib, flt, word}, 4'h8);
			end
		join
		// Chip selects only reach the idle flag, so random patterns follow the second reset release.
		for (int i = 0; i < 4; i++) begin
			cs_v = (i == 0) ? 4'hF : 4'($urandom_range(15, 0));
			m_u.set_cs(cs_v);
			@(negedge ref_clk);
			check({ib, ckib, flt, idle}, {3'h6, cs_v == 4'hF});
		end
		tally_and_finish();
	end
endmodule
